//--- verilog/clcd_core.sv
// host port, character rams and segment scan of a character display core
// Notes on behaviour
// - straps pick serial or parallel; bus width bit picks 4 or 8 bits
// - two byte registers: instruction holding and data holding
// - after a data read, next ram location is loaded into data holding
// - a data write is copied into the addressed ram automatically
// - instruction holding register is never returned on a read
// - select/read decode: instr write, status read, data write, data read
// - busy flag high during operations; instructions refused meanwhile
// - busy status read only exists on the parallel bus
// - display text ram holds 80 byte codes addressed by the counter
// - each code is a full byte selecting one of 240 fixed or 8 user glyphs
// - two-line mode: line one end and line two start not consecutive
// - display shift moves the position-to-address map, not ram contents
// - address counter steps by one after each data access
// - 16 commons in two-line mode, 8 in one-line, 40 segments
// - dots shift into a 40-bit chain, then load a 40-bit latch
// - fixed font holds 256 glyphs of 5 by 8 dots
// - code bits 2..0 form user font ram address bits 5..3
// - address bits 2..0 pick the row; row eight ors with cursor
// - row dots come from data bits 4..0, bit 4 leftmost
// - set user font bit lights a dot, cleared bit leaves it off
// - user glyphs when code bits 7..4 are zero; bit 3 ignored
// - bus width bit set means 8-bit, cleared means 4-bit transfers
// - entry direction bit set increments, cleared decrements
// - set display address loads bits 6..0 into the counter
`timescale 1ns/1ps
module clcd_core #(
  parameter int SHORT_CYC = clcd_pkg::T_SHORT_NS / clcd_pkg::CLK_PERIOD_NS,
  parameter int LONG_CYC = clcd_pkg::T_LONG_NS / clcd_pkg::CLK_PERIOD_NS
) (
  input wire logic clk,  // core clock, 250 MHz
  input wire logic rst_n,  // asynchronous reset, active low
  input wire logic iface_sel_hi,  // interface select strap, upper
  input wire logic iface_sel_lo,  // interface select strap, lower
  input wire logic host_stb,  // parallel transfer strobe, one cycle
  input wire logic register_select,  // 0 instruction/status, 1 data
  input wire logic host_rw,  // 1 read, 0 write
  input wire logic [7:0] db_in,  // parallel data lines in
  output logic [7:0] db_out,  // parallel data lines out
  output logic db_oe,  // data lines driven by the core
  input wire logic ser_valid,  // decoded serial byte strobe
  input wire logic ser_reg_sel,  // register select of the serial byte
  input wire logic [7:0] ser_byte,  // decoded serial byte
  output logic busy_flag,  // internal operation in progress
  output logic [39:0] seg_out,  // segment holding latch
  output logic [15:0] com_out  // one-hot active common
);

  typedef enum logic [1:0] {
    CLCD_IDLE = 2'b01,
    CLCD_BUSY = 2'b10
  } clcd_state_t;

  logic [7:0] display_text_ram [clcd_pkg::DD_DEPTH];
  logic [7:0] user_font_ram [clcd_pkg::CG_DEPTH];

  clcd_state_t state_q, state_d;
  logic [17:0] busy_cnt_q, busy_cnt_d;
  logic bus_width_bit_q;
  logic lines_q, font_q, id_q, eshift_q;
  logic disp_on_q, cursor_q, blink_q, tgt_cg_q;
  logic [6:0] address_counter_q;
  logic [6:0] ofs_q;
  logic [7:0] instruction_holding_q;
  logic [7:0] data_holding_q;
  logic reload_q;
  logic nib_q;
  logic [3:0] hi_nib_q;
  logic [7:0] db_out_q;
  logic [2:0] dot_q, chr_q;
  logic [3:0] row_q;
  logic [7:0] frame_q;
  logic [39:0] seg_shift_q, seg_hold_q;
  logic [15:0] com_q;

  logic par, stb, reg_sel, rd, xfer_done, busy;
  logic [7:0] in_byte, byte_w, status, rd_full;
  logic instr_take, data_wr, data_rd, op_long;
  logic [2:0] op;
  logic [6:0] line_len;
  logic [6:0] ctr_step;
  logic [6:0] dd_idx;
  logic [7:0] dd_rd;

  // position of the leading one, which selects the instruction class
  function automatic logic [2:0] lead_one(input logic [7:0] b);
    logic [2:0] r;
    r = clcd_pkg::OP_CLEAR;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : lead_one

  // display text ram index of an address; line two packs after line one
  function automatic logic [6:0] dd_index(input logic [6:0] a,
                                          input logic two);
    logic [6:0] r;
    r = a;
    if (two && a[6]) begin
      r = a - clcd_pkg::DD_L2_BASE + clcd_pkg::DD_LINE_LEN;
    end else if (two && a > clcd_pkg::DD_L1_LAST) begin
      r = 7'(clcd_pkg::DD_DEPTH);  // gap between the lines has no storage
    end
    return r;
  endfunction : dd_index

  // next display address, skipping the gap between the two lines
  function automatic logic [6:0] step_dd(input logic [6:0] a,
                                         input logic up, input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (two) begin
      if (up && a == clcd_pkg::DD_L1_LAST) begin
        r = clcd_pkg::DD_L2_BASE;
      end else if (up && a == clcd_pkg::DD_L2_LAST) begin
        r = clcd_pkg::DD_L1_BASE;
      end else if (!up && a == clcd_pkg::DD_L2_BASE) begin
        r = clcd_pkg::DD_L1_LAST;
      end else if (!up && a == clcd_pkg::DD_L1_BASE) begin
        r = clcd_pkg::DD_L2_LAST;
      end
    end else begin
      if (up && a == clcd_pkg::DD_ONE_LAST) begin
        r = clcd_pkg::DD_L1_BASE;
      end else if (!up && a == clcd_pkg::DD_L1_BASE) begin
        r = clcd_pkg::DD_ONE_LAST;
      end
    end
    return r;
  endfunction : step_dd

  // counter step for either ram target
  function automatic logic [6:0] step_ac(input logic [6:0] a,
                                         input logic up, input logic cg,
                                         input logic two);
    logic [5:0] c;
    c = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
    return cg ? {1'b0, c} : step_dd(a, up, two);
  endfunction : step_ac

  // display shift offset, wrapping over one line length
  function automatic logic [6:0] step_ofs(input logic [6:0] o,
                                          input logic left,
                                          input logic [6:0] len);
    logic [6:0] r;
    if (left) begin
      r = (o == len - 7'h01) ? 7'h00 : o + 7'h01;
    end else begin
      r = (o == 7'h00) ? len - 7'h01 : o - 7'h01;
    end
    return r;
  endfunction : step_ofs

  // fixed glyph table: 256 codes x 8 rows x 5 dots, generated pattern
  function automatic logic [4:0] fixed_font_rom(input logic [7:0] code,
                                                input logic [2:0] row);
    return code[4:0] ^ {code[7:5], row[1:0]} ^ {row, row[2:1]};
  endfunction : fixed_font_rom

  // host transfer decode
  assign par = (({iface_sel_hi, iface_sel_lo} == clcd_pkg::IFSEL_PAR) ||
                ({iface_sel_hi, iface_sel_lo} == clcd_pkg::IFSEL_PAR_ALT));
  assign stb = par ? host_stb : ser_valid;
  assign reg_sel = par ? register_select : ser_reg_sel;
  assign rd = par & host_rw;
  assign in_byte = par ? db_in : ser_byte;
  assign xfer_done = stb & (bus_width_bit_q | ~par | nib_q);
  assign byte_w = (bus_width_bit_q | ~par) ? in_byte
                                           : {hi_nib_q, db_in[7:4]};
  assign busy = (state_q == CLCD_BUSY);
  assign busy_flag = busy;
  assign status = {busy, address_counter_q};
  assign rd_full = reg_sel ? data_holding_q : status;
  assign instr_take = xfer_done & ~reg_sel & ~rd & ~busy;
  assign data_wr = xfer_done & reg_sel & ~rd & ~busy;
  assign data_rd = xfer_done & reg_sel & rd & ~busy;
  assign op = lead_one(byte_w);
  assign op_long = (op == clcd_pkg::OP_CLEAR) || (op == clcd_pkg::OP_HOME);
  assign line_len = lines_q ? clcd_pkg::DD_LINE_LEN : clcd_pkg::DD_FULL_LEN;
  assign ctr_step = step_ac(address_counter_q, id_q, tgt_cg_q, lines_q);
  assign dd_idx = dd_index(address_counter_q, lines_q);
  assign dd_rd = (dd_idx < 7'(clcd_pkg::DD_DEPTH)) ?
                 display_text_ram[dd_idx] : clcd_pkg::SPACE_CODE;
  assign db_oe = rd;
  assign db_out = db_out_q;
  assign seg_out = seg_hold_q;
  assign com_out = com_q;

  // busy sequencing
  always_comb begin
    state_d = state_q;
    busy_cnt_d = busy_cnt_q;
    case (state_q)
      CLCD_IDLE: begin
        if (instr_take) begin
          state_d = CLCD_BUSY;
          busy_cnt_d = op_long ? 18'(LONG_CYC) : 18'(SHORT_CYC);
        end else if (data_wr || data_rd) begin
          state_d = CLCD_BUSY;
          busy_cnt_d = 18'(SHORT_CYC);
        end
      end
      CLCD_BUSY: begin
        busy_cnt_d = busy_cnt_q - 18'h1;
        if (busy_cnt_q <= 18'h1) begin
          state_d = CLCD_IDLE;
        end
      end
      default: begin
        state_d = CLCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CLCD_IDLE;
      busy_cnt_q <= 18'h0;
    end else begin
      state_q <= state_d;
      busy_cnt_q <= busy_cnt_d;
    end
  end

  // nibble pairing and read data return
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nib_q <= 1'b0;
      hi_nib_q <= 4'h0;
      db_out_q <= 8'h00;
    end else begin
      if (stb && par && !bus_width_bit_q) begin
        nib_q <= ~nib_q;
        if (!nib_q) begin
          hi_nib_q <= db_in[7:4];
        end
      end else if (bus_width_bit_q || !par) begin
        nib_q <= 1'b0;
      end
      if (stb && rd) begin
        if (bus_width_bit_q) begin
          db_out_q <= rd_full;
        end else if (!nib_q) begin
          db_out_q <= {rd_full[7:4], 4'h0};
        end else begin
          db_out_q <= {rd_full[3:0], 4'h0};
        end
      end
    end
  end

  // instruction state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instruction_holding_q <= 8'h00;
      bus_width_bit_q <= clcd_pkg::RST_WIDTH;
      lines_q <= 1'b0;
      font_q <= 1'b0;
      id_q <= clcd_pkg::RST_ID;
      eshift_q <= 1'b0;
      disp_on_q <= 1'b0;
      cursor_q <= 1'b0;
      blink_q <= 1'b0;
    end else if (instr_take) begin
      instruction_holding_q <= byte_w;
      case (op)
        clcd_pkg::OP_CLEAR: id_q <= clcd_pkg::RST_ID;
        clcd_pkg::OP_ENTRY: begin
          id_q <= byte_w[clcd_pkg::ENTRY_ID_BIT];
          eshift_q <= byte_w[clcd_pkg::ENTRY_S_BIT];
        end
        clcd_pkg::OP_DISP: begin
          disp_on_q <= byte_w[clcd_pkg::DISP_D_BIT];
          cursor_q <= byte_w[clcd_pkg::DISP_C_BIT];
          blink_q <= byte_w[clcd_pkg::DISP_B_BIT];
        end
        clcd_pkg::OP_FUNC: begin
          bus_width_bit_q <= byte_w[clcd_pkg::FUNC_WIDTH_BIT];
          lines_q <= byte_w[clcd_pkg::FUNC_N_BIT];
          font_q <= byte_w[clcd_pkg::FUNC_F_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // address counter, ram target and display shift offset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      address_counter_q <= 7'h00;
      tgt_cg_q <= 1'b0;
      ofs_q <= 7'h00;
    end else if (instr_take) begin
      case (op)
        clcd_pkg::OP_CLEAR, clcd_pkg::OP_HOME: begin
          address_counter_q <= clcd_pkg::DD_L1_BASE;
          tgt_cg_q <= 1'b0;
          ofs_q <= 7'h00;
        end
        clcd_pkg::OP_SHIFT: begin
          if (byte_w[clcd_pkg::SHIFT_SC_BIT]) begin
            ofs_q <= step_ofs(ofs_q, ~byte_w[clcd_pkg::SHIFT_RL_BIT],
                              line_len);
          end else begin
            address_counter_q <= step_ac(address_counter_q,
                                         byte_w[clcd_pkg::SHIFT_RL_BIT],
                                         tgt_cg_q, lines_q);
          end
        end
        clcd_pkg::OP_CGADDR: begin
          address_counter_q <= {1'b0, byte_w[5:0]};
          tgt_cg_q <= 1'b1;
        end
        clcd_pkg::OP_DDADDR: begin
          address_counter_q <= byte_w[6:0];
          tgt_cg_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end else if (data_wr || data_rd) begin
      address_counter_q <= ctr_step;
      if (data_wr && eshift_q && !tgt_cg_q) begin
        ofs_q <= step_ofs(ofs_q, id_q, line_len);
      end
    end
  end

  // data holding register and its automatic reload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_holding_q <= 8'h00;
      reload_q <= 1'b0;
    end else begin
      reload_q <= data_rd | (instr_take && (op == clcd_pkg::OP_CGADDR ||
                                            op == clcd_pkg::OP_DDADDR));
      if (data_wr) begin
        data_holding_q <= byte_w;
      end else if (reload_q) begin
        data_holding_q <= tgt_cg_q ? user_font_ram[address_counter_q[5:0]]
                                   : dd_rd;
      end
    end
  end

  // display text ram: clear fills with spaces, data writes store bytes
  always_ff @(posedge clk) begin
    if (instr_take && op == clcd_pkg::OP_CLEAR) begin
      for (int i = 0; i < clcd_pkg::DD_DEPTH; i++) begin
        display_text_ram[i] <= clcd_pkg::SPACE_CODE;
      end
    end else if (data_wr && !tgt_cg_q &&
                 dd_idx < 7'(clcd_pkg::DD_DEPTH)) begin
      display_text_ram[dd_idx] <= byte_w;
    end
  end

  always_ff @(posedge clk) begin
    if (data_wr && tgt_cg_q) begin
      user_font_ram[address_counter_q[5:0]] <= byte_w;
    end
  end

  // segment scan: one dot per clock, 40 dots per common row
  logic [7:0] scan_sum;
  logic [6:0] scan_pos, scan_addr, scan_idx;
  logic [7:0] scan_code;
  logic [4:0] glyph;
  logic at_cursor, scan_bit, row_end, frame_end;

  assign scan_sum = {5'h00, chr_q} + {1'b0, ofs_q};
  assign scan_pos = (scan_sum >= {1'b0, line_len}) ?
                    7'(scan_sum - {1'b0, line_len}) : scan_sum[6:0];
  assign scan_addr = ((lines_q && row_q[3]) ? clcd_pkg::DD_L2_BASE
                                            : clcd_pkg::DD_L1_BASE)
                     + scan_pos;
  assign scan_idx = dd_index(scan_addr, lines_q);
  assign scan_code = display_text_ram[scan_idx];
  assign at_cursor = !tgt_cg_q && (scan_addr == address_counter_q);

  always_comb begin
    if (scan_code[7:4] == clcd_pkg::USER_CODE_HI) begin
      glyph = user_font_ram[{scan_code[2:0], row_q[2:0]}][4:0];
    end else begin
      glyph = fixed_font_rom(scan_code, row_q[2:0]);
    end
    if (cursor_q && at_cursor && row_q[2:0] == clcd_pkg::CURSOR_ROW) begin
      glyph = glyph | clcd_pkg::ALL_DOTS;
    end
    if (blink_q && at_cursor && frame_q[clcd_pkg::BLINK_BIT]) begin
      glyph = clcd_pkg::ALL_DOTS;
    end
    if (!disp_on_q) begin
      glyph = 5'h00;
    end
  end

  assign scan_bit = glyph[clcd_pkg::DOT_LAST - dot_q];
  assign row_end = (dot_q == clcd_pkg::DOT_LAST) &&
                   (chr_q == clcd_pkg::CHR_LAST);
  assign frame_end = row_end && (row_q >= (lines_q ? clcd_pkg::ROWS_2L_LAST
                                                   : clcd_pkg::ROWS_1L_LAST));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dot_q <= 3'h0;
      chr_q <= 3'h0;
      row_q <= 4'h0;
      frame_q <= 8'h00;
      seg_shift_q <= '0;
      seg_hold_q <= '0;
      com_q <= '0;
    end else begin
      seg_shift_q <= {seg_shift_q[clcd_pkg::SEG_W-2:0], scan_bit};
      dot_q <= (dot_q == clcd_pkg::DOT_LAST) ? 3'h0 : dot_q + 3'h1;
      if (dot_q == clcd_pkg::DOT_LAST) begin
        chr_q <= chr_q + 3'h1;
      end
      if (row_end) begin
        seg_hold_q <= {seg_shift_q[clcd_pkg::SEG_W-2:0], scan_bit};
        com_q <= 16'h0001 << row_q;
        row_q <= frame_end ? 4'h0 : row_q + 4'h1;
      end
      if (frame_end) begin
        frame_q <= frame_q + 8'h01;
      end
    end
  end

endmodule : clcd_core

//--- common/clcd_pkg.sv
// constants and encodings shared by the character display host core
package clcd_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SHORT_NS = 18500;  // data access and most instructions
  localparam int T_LONG_NS = 760000;  // clear display and return home
  // interface select straps {iface_sel_hi, iface_sel_lo}
  localparam logic [1:0] IFSEL_I2C = 2'h0;
  localparam logic [1:0] IFSEL_SPI = 2'h1;
  localparam logic [1:0] IFSEL_PAR = 2'h2;
  localparam logic [1:0] IFSEL_PAR_ALT = 2'h3;
  // instruction class = position of the leading one in the code
  localparam logic [2:0] OP_CLEAR = 3'h0;
  localparam logic [2:0] OP_HOME = 3'h1;
  localparam logic [2:0] OP_ENTRY = 3'h2;
  localparam logic [2:0] OP_DISP = 3'h3;
  localparam logic [2:0] OP_SHIFT = 3'h4;
  localparam logic [2:0] OP_FUNC = 3'h5;
  localparam logic [2:0] OP_CGADDR = 3'h6;
  localparam logic [2:0] OP_DDADDR = 3'h7;
  // field positions inside instruction codes
  localparam int ENTRY_S_BIT = 0;
  localparam int ENTRY_ID_BIT = 1;
  localparam int DISP_B_BIT = 0;
  localparam int DISP_C_BIT = 1;
  localparam int DISP_D_BIT = 2;
  localparam int SHIFT_RL_BIT = 2;
  localparam int SHIFT_SC_BIT = 3;
  localparam int FUNC_F_BIT = 2;
  localparam int FUNC_N_BIT = 3;
  localparam int FUNC_WIDTH_BIT = 4;
  localparam int BUSY_BIT = 7;
  // reset values of the instruction state
  localparam logic RST_WIDTH = 1'b1;
  localparam logic RST_ID = 1'b1;
  // display text ram map
  localparam int DD_DEPTH = 80;
  localparam logic [6:0] DD_LINE_LEN = 7'h28;
  localparam logic [6:0] DD_FULL_LEN = 7'h50;
  localparam logic [6:0] DD_L1_BASE = 7'h00;
  localparam logic [6:0] DD_L1_LAST = 7'h27;
  localparam logic [6:0] DD_L2_BASE = 7'h40;
  localparam logic [6:0] DD_L2_LAST = 7'h67;
  localparam logic [6:0] DD_ONE_LAST = 7'h4f;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  // user font ram
  localparam int CG_DEPTH = 64;
  localparam logic [3:0] USER_CODE_HI = 4'h0;
  // drive geometry
  localparam int SEG_W = 40;
  localparam int COM_W = 16;
  localparam logic [3:0] ROWS_1L_LAST = 4'h7;
  localparam logic [3:0] ROWS_2L_LAST = 4'hf;
  localparam logic [2:0] DOT_LAST = 3'h4;
  localparam logic [2:0] CHR_LAST = 3'h7;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  localparam logic [4:0] ALL_DOTS = 5'h1f;
  localparam int BLINK_BIT = 4;
endpackage : clcd_pkg

//--- tb/clcd_core_assertions.sv
// port checks for the character display host core
`timescale 1ns/1ps
module clcd_core_assertions #(
  parameter int SHORT_CYC = 8,
  parameter int LONG_CYC = 20
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, low
  input wire logic iface_sel_hi, // strap upper
  input wire logic iface_sel_lo, // strap lower
  input wire logic host_stb, // parallel strobe
  input wire logic register_select, // select line
  input wire logic host_rw, // 1 read
  input wire logic [7:0] db_in, // host data
  input wire logic [7:0] db_out, // read data
  input wire logic db_oe, // data drive enable
  input wire logic ser_valid, // serial strobe
  input wire logic ser_reg_sel, // serial select
  input wire logic [7:0] ser_byte, // serial byte
  input wire logic busy_flag, // busy
  input wire logic [39:0] seg_out, // segments
  input wire logic [15:0] com_out // commons
);
  logic m4_q;
  logic ph_q;
  logic two_q;
  logic [3:0] hi_q;
  int bcnt_q;
  logic stb;
  logic [7:0] cmd;
  assign stb = host_stb && iface_sel_hi;
  assign cmd = m4_q ? {hi_q, db_in[7:4]} : db_in;
  // follows bus width, nibble phase and line count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m4_q <= 1'b0;
      ph_q <= 1'b0;
      two_q <= 1'b0;
      hi_q <= 4'h0;
    end else if (stb) begin
      ph_q <= m4_q && !ph_q;
      hi_q <= db_in[7:4];
      if ((!m4_q || ph_q) && !register_select && !host_rw && !busy_flag
          && cmd[7:5] == 3'h1) begin
        m4_q <= !cmd[4];
        two_q <= cmd[3];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q <= 0;
    end else begin
      bcnt_q <= busy_flag ? bcnt_q + 1 : 0;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ser_take;
    ser_valid && !iface_sel_hi && !busy_flag;
  endsequence
  sequence s_busy_run;
    busy_flag [*7];
  endsequence
  sequence s_status_rd;
    stb && !register_select && host_rw && !ph_q;
  endsequence
  chk_ser_busy: assert property (s_ser_take |=> s_busy_run)
    else $error("serial access did not hold busy");
  chk_busy_hold: assert property ($rose(busy_flag) |-> s_busy_run)
    else $error("busy dropped early");
  chk_busy_limit: assert property (bcnt_q <= LONG_CYC)
    else $error("busy held too long");
  chk_oe_decode: assert property (db_oe == (iface_sel_hi && host_rw))
    else $error("data drive enable wrong");
  chk_status_bit: assert property (s_status_rd |=>
    db_out[7] == $past(busy_flag))
    else $error("status read lacks busy");
  chk_read_hold: assert property (!(stb && host_rw) |=> $stable(db_out))
    else $error("read data moved without read");
  chk_com_onehot: assert property ($onehot0(com_out))
    else $error("more than one common active");
  chk_com_lines: assert property (!two_q |-> com_out[15:8] == 8'h00)
    else $error("upper commons in one-line mode");
  chk_scan_steady: assert property (($changed(com_out) ||
    $changed(seg_out)) |=> ($stable(com_out) && $stable(seg_out)) [*8])
    else $error("segment latch changed mid row");
endmodule : clcd_core_assertions
bind clcd_core clcd_core_assertions #(.SHORT_CYC(SHORT_CYC),
  .LONG_CYC(LONG_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
  .iface_sel_hi(iface_sel_hi), .iface_sel_lo(iface_sel_lo),
  .host_stb(host_stb), .register_select(register_select),
  .host_rw(host_rw), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
  .ser_valid(ser_valid), .ser_reg_sel(ser_reg_sel), .ser_byte(ser_byte),
  .busy_flag(busy_flag), .seg_out(seg_out), .com_out(com_out));

//--- tb/clcd_host_model.sv
// host processor model for the parallel and serial host port
`timescale 1ns/1ps
module clcd_host_model (
  input wire logic clk, // core clock
  output logic host_stb, // transfer strobe
  output logic register_select, // 0 instr/status
  output logic host_rw, // 1 read
  output logic [7:0] db_in, // lines to core
  input wire logic [7:0] db_out, // lines from core
  output logic ser_valid, // serial strobe
  output logic ser_reg_sel, // serial select
  output logic [7:0] ser_byte // serial byte
);
  logic m4 = 1'b0;
  initial begin
    host_stb = 1'b0;
    register_select = 1'b0;
    host_rw = 1'b0;
    db_in = 8'h00;
    ser_valid = 1'b0;
    ser_reg_sel = 1'b0;
    ser_byte = 8'h00;
  end
  task automatic strobe(input logic sel, input logic rw,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    host_stb = 1'b1;
    register_select = sel;
    host_rw = rw;
    db_in = d;
    @(posedge clk);
    #1;
    host_stb = 1'b0;
    db_in = ~d; // released lines never keep the last value
    @(posedge clk);
    #1;
    q = db_out;
  endtask : strobe
  task automatic xfer(input logic sel, input logic rw,
                      input logic [7:0] d, output logic [7:0] q);
    logic [7:0] h;
    if (m4) begin
      strobe(sel, rw, d, h);
      strobe(sel, rw, {d[3:0], 4'h0}, q);
      q = {h[7:4], q[7:4]};
    end else begin
      strobe(sel, rw, d, q);
    end
  endtask : xfer
  task automatic poll();
    logic [7:0] s;
    for (int i = 0; i < 60; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      if (s[7] === 1'b0) break;
    end
  endtask : poll
  task automatic ser_send(input logic sel, input logic [7:0] d);
    @(posedge clk);
    #1;
    ser_valid = 1'b1;
    ser_reg_sel = sel;
    ser_byte = d;
    @(posedge clk);
    #1;
    ser_valid = 1'b0;
    ser_byte = ~d;
  endtask : ser_send
endmodule : clcd_host_model

//--- tb/tb.sv
// self-checking bench for the character display core
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic sel;
    logic rw;
    logic [7:0] d;
    logic [7:0] ex;
  } clcd_row_t;
  logic clk;
  logic rst_n;
  logic sel_hi;
  logic sel_lo;
  logic host_stb;
  logic register_select;
  logic host_rw;
  logic [7:0] db_in;
  logic [7:0] db_out;
  logic db_oe;
  logic ser_valid;
  logic ser_reg_sel;
  logic [7:0] ser_byte;
  logic busy_flag;
  logic [39:0] seg_out;
  logic [15:0] com_out;
  logic [7:0] q;
  int error_cnt = 0;
  int num_checks = 0;
  clcd_row_t rows [26] = '{
    '{1'b0, 1'b1, 8'h00, 8'h00}, '{1'b0, 1'b0, 8'h38, 8'h00},
    '{1'b0, 1'b0, 8'h06, 8'h00}, '{1'b0, 1'b0, 8'ha7, 8'h00},
    '{1'b1, 1'b0, 8'h41, 8'h00}, '{1'b0, 1'b1, 8'h00, 8'h40},
    '{1'b1, 1'b0, 8'h42, 8'h00}, '{1'b0, 1'b0, 8'ha7, 8'h00},
    '{1'b1, 1'b1, 8'h00, 8'h41}, '{1'b1, 1'b1, 8'h00, 8'h42},
    '{1'b0, 1'b1, 8'h00, 8'h41}, '{1'b0, 1'b0, 8'h04, 8'h00},
    '{1'b0, 1'b0, 8'hc0, 8'h00}, '{1'b1, 1'b0, 8'h43, 8'h00},
    '{1'b0, 1'b1, 8'h00, 8'h27}, '{1'b0, 1'b0, 8'h06, 8'h00},
    '{1'b0, 1'b0, 8'h14, 8'h00}, '{1'b0, 1'b1, 8'h00, 8'h40},
    '{1'b0, 1'b0, 8'h48, 8'h00}, '{1'b1, 1'b0, 8'h1f, 8'h00},
    '{1'b0, 1'b1, 8'h00, 8'h09}, '{1'b0, 1'b0, 8'h48, 8'h00},
    '{1'b1, 1'b1, 8'h00, 8'h1f}, '{1'b0, 1'b0, 8'h01, 8'h00},
    '{1'b0, 1'b0, 8'h80, 8'h00}, '{1'b1, 1'b1, 8'h00, 8'h20}};
  clcd_core #(.SHORT_CYC(8), .LONG_CYC(20)) u_dut (.clk(clk),
    .rst_n(rst_n), .iface_sel_hi(sel_hi), .iface_sel_lo(sel_lo),
    .host_stb(host_stb), .register_select(register_select),
    .host_rw(host_rw), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .ser_valid(ser_valid), .ser_reg_sel(ser_reg_sel), .ser_byte(ser_byte),
    .busy_flag(busy_flag), .seg_out(seg_out), .com_out(com_out));
  clcd_host_model u_host (.clk(clk), .host_stb(host_stb),
    .register_select(register_select), .host_rw(host_rw),
    .db_in(db_in), .db_out(db_out), .ser_valid(ser_valid),
    .ser_reg_sel(ser_reg_sel), .ser_byte(ser_byte));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(busy_flag, 1'b0);
    check(com_out, 16'h0000);
    rst_n = 1'b1;
  endtask : reset_dut
  // the whole run needs under two thousand cycles
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    reset_dut();
    foreach (rows[i]) begin
      u_host.poll();
      u_host.xfer(rows[i].sel, rows[i].rw, rows[i].d, q);
      if (rows[i].rw) check(q, rows[i].ex);
    end
    // a data write landing while busy is dropped
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h80, q);
    u_host.xfer(1'b1, 1'b0, 8'h55, q);
    u_host.poll();
    u_host.xfer(1'b0, 1'b1, 8'h00, q);
    check(q, 8'h00);
    u_host.xfer(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h20);
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h28, q);
    u_host.m4 = 1'b1;
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h85, q);
    u_host.poll();
    u_host.xfer(1'b0, 1'b1, 8'h00, q);
    check(q, 8'h05);
    u_host.xfer(1'b1, 1'b0, 8'h5a, q);
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h85, q);
    u_host.poll();
    u_host.xfer(1'b1, 1'b1, 8'h00, q);
    check(q, 8'h5a);
    u_host.m4 = 1'b0;
    sel_hi = 1'b0;
    sel_lo = 1'b1;
    reset_dut();
    u_host.ser_send(1'b1, 8'h61);
    #1;
    check(db_oe, 1'b0);
    repeat (30) @(posedge clk);
    #1;
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    u_host.xfer(1'b0, 1'b1, 8'h00, q);
    check(q, 8'h01);
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h40, q);
    repeat (8) begin
      u_host.poll();
      u_host.xfer(1'b1, 1'b0, 8'hf8, q);
    end
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h80, q);
    u_host.poll();
    u_host.xfer(1'b1, 1'b0, 8'h08, q);
    u_host.poll();
    u_host.xfer(1'b0, 1'b0, 8'h0c, q);
    repeat (400) @(posedge clk);
    #1;
    for (int k = 0; k < 400 && com_out[0] !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check(com_out, 16'h0001);
    check(seg_out[39:35], 5'h18);
    print_verdict();
  end
endmodule : tb
